/* File: logic/sar_conv_ctrl.sv */
// conversion sequencer and serial read-out for a differential sar converter
// Operation
// - a convert-start rising edge with the serial input high selects chip-select operation.
// - a convert-start rising edge with the serial input low selects daisy-chain operation.
// - either operation may put one busy bit ahead of the result bits.
// - chip-select covers 3-wire and 4-wire, each with or without busy bit.
// - conversion runs on the internal clock for a varying time within min and max.
// - the serial clock only shifts out results and never times a conversion.
// - the result is the two's complement code of positive minus negative input.
// - at conversion start the input is captured and both inputs stay disconnected.
// - after conversion the sampling capacitors reconnect and acquisition begins.
// - during acquisition the device is powered down, draws no reference current, stays readable.
// - the code scale spans minus to plus reference, twice the reference in all.
// - in chip-select operation the start edge tri-states the output and starts a conversion.
// - the host sets select to its chosen busy level inside the conversion window.
// - without busy, msb shows on select fall, shifts on sclk falls, releases after 18 or select rise.
// - with busy, output goes low at conversion end, then msb first, releases after 19 or select rise.
`timescale 1ns/1ns
`include "sar_ctrl_params.svh"
module sar_conv_ctrl #(
  parameter int CODE_BITS = `SAR_CODE_BITS
) (
  input  wire logic                  clk_sys_in,             // 20 MHz internal clock
  input  wire logic                  rst_n_in,               // async reset, active low
  input  wire logic                  sclk_in,                // host serial clock
  input  wire logic                  convert_start_pin_in,   // convert start / select
  input  wire logic                  serial_in,              // mode strap / select
  input  wire logic [CODE_BITS-1:0]  positive_analog_input_in, // digitised positive input
  input  wire logic [CODE_BITS-1:0]  negative_analog_input_in, // digitised negative input
  output logic                       dout_out,               // serial data
  output logic                       dout_oe_out,            // serial data drive enable
  output logic                       sample_capture_out,     // sampling switch opens
  output logic                       inputs_isolate_out,     // inputs disconnected
  output logic                       power_down_out,         // analog core powered down
  output logic                       ref_load_out,           // reference being switched
  output logic                       daisy_mode_out          // daisy-chain selected
);

  localparam int FRAME_BITS = CODE_BITS + 1;
  localparam logic [`SAR_CNT_BITS-1:0] LEN_PLAIN = `SAR_CNT_BITS'(CODE_BITS);
  localparam logic [`SAR_CNT_BITS-1:0] LEN_BUSY  = `SAR_CNT_BITS'(FRAME_BITS);
  localparam logic [`SAR_CNT_BITS-1:0] CONV_MIN  = `SAR_CNT_BITS'(`SAR_CONV_MIN_CYC);
  localparam logic [`SAR_CNT_BITS-1:0] CONV_MAX  = `SAR_CNT_BITS'(`SAR_CONV_MAX_CYC);
  localparam int                       CONV_LO   = `SAR_CONV_MIN_CYC;
  localparam int                       CONV_HI   = `SAR_CONV_MAX_CYC;

  // pin synchronisers; stage one feeds only stage two
  logic                   cnv_s1_r, cnv_s2_r, cnv_q_r;
  logic                   din_s1_r, din_s2_r;
  logic [CODE_BITS-1:0]   pos_s1_r, pos_s2_r, neg_s1_r, neg_s2_r;

  // sys domain state
  sar_ctrl_pkg::conv_state_t  state_r, state_nxt;
  sar_ctrl_pkg::read_mode_t   mode_r;
  sar_ctrl_pkg::out_frame_t   frame_r;
  logic [`SAR_CNT_BITS-1:0]   conv_cnt_r, conv_len_r;
  logic [`SAR_LFSR_BITS-1:0]  lfsr_r;
  logic [CODE_BITS-1:0]       held_pos_r, held_neg_r;
  logic                       read_en_r, read_en_nxt;
  logic                       capture_r;

  // link domain state
  logic [`SAR_CNT_BITS-1:0]   edge_cnt_r;

  // decode
  wire logic                  start_w;
  wire logic                  done_w;
  wire logic                  sel_n_w;
  wire logic [CODE_BITS:0]    diff_w;
  wire logic [`SAR_CNT_BITS-1:0] dur_w;
  wire logic [`SAR_CNT_BITS-1:0] len_w;
  wire logic [`SAR_CNT_BITS-1:0] bit_idx_w;
  wire logic                  link_rst_n_w;
  wire logic                  lfsr_fb_w;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // convert chain resets high: a pin already high at release is no start edge
      cnv_s1_r <= 1'b1;
      cnv_s2_r <= 1'b1;
      cnv_q_r  <= 1'b1;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      pos_s1_r <= '0;
      pos_s2_r <= '0;
      neg_s1_r <= '0;
      neg_s2_r <= '0;
    end else begin
      cnv_s1_r <= convert_start_pin_in;
      cnv_s2_r <= cnv_s1_r;
      cnv_q_r  <= cnv_s2_r;
      din_s1_r <= serial_in;
      din_s2_r <= din_s1_r;
      pos_s1_r <= positive_analog_input_in;
      pos_s2_r <= pos_s1_r;
      neg_s1_r <= negative_analog_input_in;
      neg_s2_r <= neg_s1_r;
    end
  end

  // edges during a conversion are ignored so the running mode cannot change
  assign start_w = cnv_s2_r && !cnv_q_r && (state_r != sar_ctrl_pkg::ST_CONV);
  assign done_w  = (state_r == sar_ctrl_pkg::ST_CONV) && (conv_cnt_r == conv_len_r);

  // select is low-active: 3-wire ties din high, 4-wire holds convert_start_pin high
  assign sel_n_w = (mode_r == sar_ctrl_pkg::MODE_CS) ? (cnv_s2_r && din_s2_r)
                                                     : cnv_s2_r;

  // free-running lfsr lets the conversion length wander inside its window
  assign lfsr_fb_w = ^(lfsr_r & `SAR_LFSR_TAPS);
  assign dur_w = CONV_MIN + `SAR_CNT_BITS'(lfsr_r[2:0])
               + `SAR_CNT_BITS'(lfsr_r[3]);

  // half of the 19-bit difference: span of twice the reference fills the code
  assign diff_w = {1'b0, held_pos_r} - {1'b0, held_neg_r};

  // state sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sar_ctrl_pkg::ST_IDLE: begin
        if (start_w) state_nxt = sar_ctrl_pkg::ST_CONV;
      end
      sar_ctrl_pkg::ST_CONV: begin
        if (done_w) state_nxt = sar_ctrl_pkg::ST_ACQ;
      end
      sar_ctrl_pkg::ST_ACQ: begin
        if (start_w) state_nxt = sar_ctrl_pkg::ST_CONV;
      end
    endcase
  end

  // read window: opens at conversion end when selected (busy) or on select fall
  always_comb begin
    read_en_nxt = read_en_r;
    if (start_w) begin
      read_en_nxt = 1'b0;
    end else if (done_w) begin
      read_en_nxt = !sel_n_w;
    end else if (state_r == sar_ctrl_pkg::ST_ACQ) begin
      read_en_nxt = !sel_n_w;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r   <= sar_ctrl_pkg::ST_IDLE;
      read_en_r <= 1'b0;
      lfsr_r    <= `SAR_LFSR_SEED;
      capture_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      read_en_r <= read_en_nxt;
      lfsr_r    <= {lfsr_r[`SAR_LFSR_BITS-2:0], lfsr_fb_w};
      capture_r <= start_w;
    end
  end

  // conversion timing from the internal clock only
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_cnt_r <= '0;
      conv_len_r <= CONV_MIN;
    end else if (start_w) begin
      conv_cnt_r <= `SAR_CNT_BITS'(1);
      conv_len_r <= dur_w;
    end else if (state_r == sar_ctrl_pkg::ST_CONV && !done_w) begin
      conv_cnt_r <= conv_cnt_r + `SAR_CNT_BITS'(1);
    end
  end

  // mode strap and input sample taken at the start edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r     <= sar_ctrl_pkg::MODE_CS;
      held_pos_r <= '0;
      held_neg_r <= '0;
    end else if (start_w) begin
      mode_r     <= din_s2_r ? sar_ctrl_pkg::MODE_CS
                             : sar_ctrl_pkg::MODE_DAISY;
      held_pos_r <= pos_s2_r;
      held_neg_r <= neg_s2_r;
    end
  end

  // frame only changes while the link side is held in reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_r <= '0;
    end else if (done_w) begin
      frame_r.busy_en <= !sel_n_w;
      frame_r.code    <= diff_w[CODE_BITS:1];
    end
  end

  // link domain: cleared whenever the read window is closed, so a stopped
  // sclk is harmless and select rise ends the frame without any sclk edge
  assign link_rst_n_w = rst_n_in && read_en_r;
  assign len_w = frame_r.busy_en ? LEN_BUSY : LEN_PLAIN;

  always_ff @(negedge sclk_in or negedge link_rst_n_w) begin
    if (!link_rst_n_w) begin
      edge_cnt_r <= '0;
    end else if (edge_cnt_r < len_w) begin
      edge_cnt_r <= edge_cnt_r + `SAR_CNT_BITS'(1);
    end
  end

  // first bit is busy (0) or msb; each falling edge steps one bit lower
  assign bit_idx_w = len_w - `SAR_CNT_BITS'(1) - edge_cnt_r;

  // output stage
  always_comb begin
    dout_out = 1'b0;
    if (edge_cnt_r < len_w && (!frame_r.busy_en || edge_cnt_r != '0)) begin
      dout_out = frame_r.code[bit_idx_w];
    end
  end

  assign dout_oe_out = read_en_r && (edge_cnt_r < len_w);

  // analog front-end controls; reference only loaded while converting
  assign sample_capture_out = capture_r;
  assign inputs_isolate_out = (state_r == sar_ctrl_pkg::ST_CONV);
  assign power_down_out     = (state_r != sar_ctrl_pkg::ST_CONV);
  assign ref_load_out       = (state_r == sar_ctrl_pkg::ST_CONV);
  assign daisy_mode_out     = (mode_r == sar_ctrl_pkg::MODE_DAISY);

  // checks, sys domain
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  a_cs_mode_pick: assert property (
    start_w && din_s2_r |=> mode_r == sar_ctrl_pkg::MODE_CS)
    else $error("cs mode not selected with din high");

  a_daisy_mode_pick: assert property (
    start_w && !din_s2_r |=> daisy_mode_out)
    else $error("daisy mode not selected with din low");

  a_mode_held_conv: assert property (
    state_r == sar_ctrl_pkg::ST_CONV |=> $stable(mode_r) || $past(start_w))
    else $error("mode changed inside a cycle");

  a_conv_time_window: assert property (
    done_w |-> conv_cnt_r >= CONV_MIN && conv_cnt_r <= CONV_MAX)
    else $error("conversion length outside window");

  a_conv_ends_late: assert property (
    start_w |=> inputs_isolate_out [*8] ##1 inputs_isolate_out)
    else $error("conversion ended before minimum time");

  a_code_twos_comp: assert property (
    done_w |=> frame_r.code == $past(diff_w[CODE_BITS:1]))
    else $error("result code not difference of inputs");

  a_isolate_power: assert property (
    inputs_isolate_out |-> !power_down_out && ref_load_out)
    else $error("inputs connected or powered down during conversion");

  a_reconnect_acq: assert property (
    done_w |=> state_r == sar_ctrl_pkg::ST_ACQ && !inputs_isolate_out && power_down_out)
    else $error("no acquisition after conversion");

  a_start_tristate: assert property (
    start_w |=> !dout_oe_out [*2])
    else $error("output driven after start edge");

  a_busy_low_end: assert property (
    done_w && !sel_n_w |=> dout_oe_out && !dout_out)
    else $error("busy bit not driven low at conversion end");

  a_select_release: assert property (
    state_r == sar_ctrl_pkg::ST_ACQ && sel_n_w && !start_w |=> !dout_oe_out)
    else $error("output driven with select high");

  a_capture_one_shot: assert property (
    start_w |=> sample_capture_out ##1 !sample_capture_out)
    else $error("capture pulse not one cycle");

  a_mode_only_start: assert property (
    !start_w |=> $stable(mode_r))
    else $error("mode changed without a start edge");

  a_conv_len_bound: assert property (
    start_w |-> ##[CONV_LO:CONV_HI] done_w)
    else $error("conversion did not end inside window");

  a_acq_quiet: assert property (
    state_r == sar_ctrl_pkg::ST_ACQ |-> power_down_out && !ref_load_out && !inputs_isolate_out)
    else $error("core active during acquisition");

  a_msb_on_select: assert property (
    state_r == sar_ctrl_pkg::ST_ACQ && $fell(sel_n_w) && !start_w && !frame_r.busy_en
    |=> dout_oe_out && dout_out == frame_r.code[CODE_BITS-1])
    else $error("msb not driven after select fall");

  c_cs_busy: cover property (done_w && !sel_n_w && mode_r == sar_ctrl_pkg::MODE_CS);
  c_cs_plain: cover property (done_w ##[1:20] (read_en_r && !frame_r.busy_en));
  c_daisy_conv: cover property (done_w && daisy_mode_out);
  c_full_read: cover property (read_en_r && edge_cnt_r == len_w);
  c_daisy_busy: cover property (done_w && !sel_n_w && daisy_mode_out);

endmodule

/* File: logic/sar_ctrl_params.svh */
// timing and format constants for the sar conversion controller
`ifndef SAR_CTRL_PARAMS_SVH
`define SAR_CTRL_PARAMS_SVH
`define SAR_CLK_NS       50
`define SAR_CONV_MIN_NS  500
`define SAR_CONV_MAX_NS  930
`define SAR_CONV_MIN_CYC ((`SAR_CONV_MIN_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CONV_MAX_CYC (`SAR_CONV_MAX_NS / `SAR_CLK_NS)
`define SAR_CODE_BITS    18
`define SAR_CNT_BITS     5
`define SAR_LFSR_BITS    8
`define SAR_LFSR_SEED    8'hA5
`define SAR_LFSR_TAPS    8'hB8
`endif

/* File: logic/sar_ctrl_pkg.sv */
// types shared by the sar conversion controller
package sar_ctrl_pkg;
  typedef enum logic {MODE_CS, MODE_DAISY} read_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ACQ} conv_state_t;
  // read-out frame handed to the serial clock domain
  typedef struct packed {
    logic        busy_en;
    logic [17:0] code;
  } out_frame_t;
endpackage

/* File: verification/spi_host_model.sv */
// host side model: serial clock bursts and bit capture
`timescale 1ns/1ns
module spi_host_model (
  input  wire logic dout_in,    // device serial data
  input  wire logic dout_oe_in, // device drive enable
  output logic      sclk_out    // serial clock, still outside frames
);
  int unsigned undriven_cnt; // bits taken while the device had let go
  // pull-up holds a released line high, so a stale bit cannot pass
  wire logic   dout_seen = dout_oe_in ? dout_in : 1'b1;

  // clock idles low between frames, so no stray falling edge
  initial begin
    sclk_out = 1'b0;
    undriven_cnt = 0;
  end

  // n clocks at 15 ns, bit taken on each rise ahead of its fall
  task automatic read_frame(input int n, output logic [18:0] data);
    data = 19'h0;
    for (int i = 0; i < n; i++) begin
      #7 sclk_out = 1'b1;
      data = {data[17:0], dout_seen};
      if (dout_oe_in !== 1'b1) undriven_cnt++;
      #8 sclk_out = 1'b0;
    end
  endtask
endmodule

/* File: verification/sar_conv_ctrl_tb.sv */
// self-checking bench for the sar conversion controller
`timescale 1ns/1ns
module sar_conv_ctrl_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cnv = 1'b0;
  logic        din = 1'b1;
  logic [17:0] pos = 18'h0;
  logic [17:0] neg = 18'h0;
  logic        sclk, dout, oe, cap, iso, pd, refl, dsy;
  int          error_cnt = 0;
  int          checks_done = 0;

  // 20 MHz system clock
  always #25 clk = ~clk;

  sar_conv_ctrl sar_conv_ctrl_i (.clk_sys_in(clk), .rst_n_in(rst_n), .sclk_in(sclk),
    .convert_start_pin_in(cnv), .serial_in(din), .positive_analog_input_in(pos),
    .negative_analog_input_in(neg), .dout_out(dout), .dout_oe_out(oe),
    .sample_capture_out(cap), .inputs_isolate_out(iso), .power_down_out(pd),
    .ref_load_out(refl), .daisy_mode_out(dsy));
  spi_host_model spi_host_model_i (.dout_in(dout), .dout_oe_in(oe), .sclk_out(sclk));

  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one comparison, four-state exact
  task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    chk(what, {18'h0, seen}, {18'h0, exp});
  endtask

  // bounded wait for a conversion to start; a stuck output ends the run
  task automatic wait_conv();
    int n;
    n = 0;
    while (iso !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8) begin
        chk1("conversion start", iso, 1'b1);
        tally_and_finish();
      end
    end
  endtask

  // half of the 19-bit difference, as a two's complement code
  function automatic logic [17:0] code_of(input logic [17:0] p, input logic [17:0] n);
    logic [18:0] d;
    d = {1'b0, p} - {1'b0, n};
    return d[18:1];
  endfunction

  // start edge with a strap level, then the mid-conversion select move
  task automatic start_conv(input logic strap, input logic on_din, input logic busy);
    int len;
    @(posedge clk);
    din <= strap;
    cnv <= 1'b0;
    repeat (12) @(posedge clk);
    cnv <= 1'b1;
    wait_conv();
    chk1("capture pulse", cap, 1'b1);
    chk1("output released", oe, 1'b0);
    chk1("reference switched", refl, 1'b1);
    chk1("powered in conversion", pd, 1'b0);
    @(posedge clk);
    if (busy && on_din) din <= 1'b0;
    else if (busy) cnv <= 1'b0;
    else din <= 1'b1; // a late strap move must not change the mode
    #1;
    chk1("capture one cycle", cap, 1'b0);
    len = 1;
    while (iso === 1'b1 && len < 30) begin
      @(posedge clk);
      #1;
      len++;
    end
    chk1("length in window", len >= 10 && len <= 18, 1'b1);
    chk1("powered down after", pd, 1'b1);
    chk1("reference quiet", refl, 1'b0);
    chk1("daisy flag", dsy, ~strap);
  endtask

  // open the read window and clock n bits out through the host
  task automatic read_out(input logic on_din, input logic busy, input int n,
                          input logic [18:0] exp);
    logic [18:0] got;
    @(posedge clk);
    if (!busy && on_din) din <= 1'b0;
    else if (!busy) cnv <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk1("output driven", oe, 1'b1);
    chk1("first bit", dout, exp[n-1]);
    #12;
    spi_host_model_i.read_frame(n, got);
    chk("frame", got, exp);
    chk("bits while released", 19'(spi_host_model_i.undriven_cnt), 19'h0);
  endtask

  // all four chip-select variants with boundary codes
  task automatic t_cs_variants();
    logic [17:0] p [4] = '{18'h3FFFF, 18'h00000, 18'h20000, 18'h12345};
    logic [17:0] q [4] = '{18'h00000, 18'h3FFFF, 18'h20000, 18'h0ABCD};
    for (int v = 0; v < 4; v++) begin
      @(posedge clk);
      pos <= p[v];
      neg <= q[v];
      start_conv(1'b1, v[1], v[0]);
      read_out(v[1], v[0], 18 + v[0], {1'b0, code_of(p[v], q[v])});
      repeat (4) @(posedge clk);
      #1;
      chk1("released after last edge", oe, 1'b0);
    end
    $display("test chip-select variants done");
  endtask

  // strap low selects daisy, read with the convert pin alone
  task automatic t_daisy();
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      pos <= 18'h00001;
      neg <= 18'h00004;
      start_conv(1'b0, 1'b0, b[0]);
      read_out(1'b0, b[0], 18 + b, {1'b0, code_of(18'h00001, 18'h00004)});
    end
    $display("test daisy-chain done");
  endtask

  // select rises mid-frame: output must let go on the third clock after it, with no sclk edge
  task automatic t_abort();
    logic [17:0] c;
    c = code_of(18'h2AAAA, 18'h05555);
    @(posedge clk);
    pos <= 18'h2AAAA;
    neg <= 18'h05555;
    start_conv(1'b1, 1'b1, 1'b0);
    read_out(1'b1, 1'b0, 9, {10'h0, c[17:9]});
    @(posedge clk);
    din <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk1("driven until select seen", oe, 1'b1);
    @(posedge clk);
    #1;
    chk1("released on select rise", oe, 1'b0);
    $display("test read abort done");
  endtask

  // reset in mid-conversion returns every output to idle
  task automatic t_reset_mid();
    @(posedge clk);
    cnv <= 1'b0;
    din <= 1'b0;
    repeat (12) @(posedge clk);
    cnv <= 1'b1;
    wait_conv();
    chk1("daisy before reset", dsy, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk1("isolate in reset", iso, 1'b0);
    chk1("power down in reset", pd, 1'b1);
    chk1("daisy in reset", dsy, 1'b0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // convert pin still high at release: no start may follow
    repeat (4) begin
      @(posedge clk);
      #1;
      chk1("no start after reset", iso, 1'b0);
      chk1("output off after reset", oe, 1'b0);
    end
    @(posedge clk);
    cnv <= 1'b0;
    din <= 1'b1;
    repeat (12) @(posedge clk);
    cnv <= 1'b1;
    wait_conv();
    chk1("cs after reset", dsy, 1'b0);
    $display("test mid-run reset done");
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk1("idle power down", pd, 1'b1);
    chk1("idle output off", oe, 1'b0);
    t_cs_variants();
    t_daisy();
    t_abort();
    t_reset_mid();
    tally_and_finish();
  end
endmodule
